//--- logic/row_repair_pkg.sv
// Shared constants for the permanent row repair logic, plus the pin synchroniser.
// Assumes a single 10 MHz command clock and an active-low asynchronous reset.
package row_repair_pkg;
  // Command clock rate.
  localparam int unsigned CLK_KHZ = 10000;
  localparam int unsigned CLK_MHZ = 10;

  // Programming wait, exit time and post-exit setting time, each with its cycle count.
  localparam int unsigned PROG_TIME_MS = 2000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * CLK_KHZ;
  localparam int unsigned EXIT_TIME_NS = 15;
  localparam int unsigned EXIT_CYCLES_RAW = (EXIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EXIT_CYCLES = (EXIT_CYCLES_RAW < 1) ? 1 : EXIT_CYCLES_RAW;
  localparam int unsigned SET_TIME_US = 50;
  localparam int unsigned SET_CYCLES = SET_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 25;

  // Data window lengths in clocks.
  localparam logic [2:0] WIN_LEN = 3'h4;
  localparam logic [2:0] HIGH_RUN = 3'h2;

  // Decoded command codes on the command bus.
  localparam logic [2:0] CMD_MRS = 3'h1;
  localparam logic [2:0] CMD_ACT = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h3;
  localparam logic [2:0] CMD_WRA = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h5;
  localparam logic [2:0] CMD_REF = 3'h6;

  // Mode register numbers taken from {bank group bit 0, bank address}.
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_FOUR = 3'h4;
  localparam int unsigned ENTRY_BIT = 13;
  localparam logic [3:0] GUARD_WRITES = 4'h4;

  // Register port offsets and fields.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SUPPORT = 4'h8;
  localparam logic [3:0] REG_LAST_ROW = 4'hC;
  localparam logic [4:0] WL_RESET = 5'h0A;
  localparam int unsigned SUP_PERM_BIT = 7;
  localparam int unsigned SUP_TEMP_BIT = 6;

  // Outcome of the data window.
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_REPAIR = 2'h1;
  localparam logic [1:0] OUT_SKIP = 2'h2;
  localparam logic [1:0] OUT_UNKNOWN = 2'h3;

  typedef enum logic [10:0] {
    ST_NORMAL = 11'h001,
    ST_KEY = 11'h002,
    ST_ARMED = 11'h004,
    ST_ROW_OPEN = 11'h008,
    ST_WL_WAIT = 11'h010,
    ST_DATA = 11'h020,
    ST_PROGRAM = 11'h040,
    ST_WAIT_PRE = 11'h080,
    ST_EXIT_WAIT = 11'h100,
    ST_WAIT_EXIT = 11'h200,
    ST_SETTLE = 11'h400
  } repair_state_t;
endpackage : row_repair_pkg

////////////////////////////////////////////////////////////////////////////////

// Two-stage synchroniser for a bundle of pin inputs.
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Bundle.
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_one <= '0;
      synced <= '0;
    end else begin
      stage_one <= pins;
      synced <= stage_one;
    end
  end
endmodule : pin_sync

//--- logic/row_repair.sv
// Permanent row repair sequencer inside the memory device, with its register port.
// Assumes the command bus is decoded into codes outside and arrives from pins.
module row_repair
  import row_repair_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
  parameter int unsigned ROWS = 8,
  parameter bit PERM_SUPPORT = 1'b1,
  parameter bit TEMP_SUPPORT = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Decoded command bus and data lines, from pins.
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [1:0] cmd_bg,
  input wire logic [1:0] cmd_ba,
  input wire logic [17:0] cmd_addr,
  input wire logic [15:0] dq,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Array side.
  output logic repair_mode,
  output logic accept_cmd,
  output logic fuse_fire,
  output logic [17:0] fuse_row,
  output logic [2:0] fuse_bank,
  output logic refresh_go,
  output logic [7:0] refresh_keep,
  output logic remap_hit,
  output logic [7:0] support_page
);
  localparam int unsigned BUS_W = 42;
  localparam int unsigned IDX_W = $clog2(ROWS);
  localparam logic [TIMER_W-1:0] PROG_LOAD = TIMER_W'(PROG_CYCLES_P - 1);
  localparam logic [TIMER_W-1:0] EXIT_LOAD = TIMER_W'(EXIT_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SET_LOAD = TIMER_W'(SET_CYCLES - 1);

  logic s_valid;
  logic [2:0] s_code;
  logic [1:0] s_bg;
  logic [1:0] s_ba;
  logic [17:0] s_addr;
  logic [15:0] s_dq;

  pin_sync #(.WIDTH(BUS_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pins({cmd_valid, cmd_code, cmd_bg, cmd_ba, cmd_addr, dq}),
    .synced({s_valid, s_code, s_bg, s_ba, s_addr, s_dq})
  );

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic is_cmd(input logic v, input logic [2:0] c, input logic [2:0] want);
    is_cmd = v && (c == want);
  endfunction : is_cmd

  function automatic logic [2:0] bank_of(input logic [1:0] bg, input logic [1:0] ba);
    bank_of = {bg[0], ba};
  endfunction : bank_of

  repair_state_t state;
  repair_state_t next_state;
  logic [TIMER_W-1:0] timer;
  logic [3:0] key_count;
  logic [4:0] wl_count;
  logic [4:0] write_latency;
  logic [2:0] win_count;
  logic [2:0] high_run;
  logic all_low;
  logic saw_skip;
  logic [1:0] outcome;
  logic auto_pre;
  logic disturbed;
  logic [17:0] target_row;
  logic [2:0] target_bank;
  logic [7:0] repair_count;
  logic [IDX_W-1:0] fill;
  logic [ROWS-1:0] row_used;
  logic [17:0] row_table [ROWS];
  logic [2:0] bank_table [ROWS];

  logic mrs_four;
  logic entry_set;
  logic entry_clear;
  logic mrs_zero;
  logic is_ref;
  logic dq_low;
  logic dq_high;

  always_comb begin
    mrs_four = is_cmd(s_valid, s_code, CMD_MRS) && (bank_of(s_bg, s_ba) == MR_FOUR);
    entry_set = mrs_four && s_addr[ENTRY_BIT];
    entry_clear = mrs_four && !s_addr[ENTRY_BIT];
    mrs_zero = is_cmd(s_valid, s_code, CMD_MRS) && (bank_of(s_bg, s_ba) == MR_ZERO);
    is_ref = is_cmd(s_valid, s_code, CMD_REF);
    dq_low = (s_dq == '0);
    dq_high = (s_dq == '1);
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (entry_set) begin
          next_state = ST_KEY;
        end
      end
      ST_KEY: begin
        if (mrs_zero && (key_count == GUARD_WRITES - 4'h1)) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (is_cmd(s_valid, s_code, CMD_ACT)) begin
          next_state = ST_ROW_OPEN;
        end
      end
      ST_ROW_OPEN: begin
        // The first window sample lands write latency after the write; zero acts as one.
        if (is_cmd(s_valid, s_code, CMD_WR) || is_cmd(s_valid, s_code, CMD_WRA)) begin
          next_state = (write_latency <= 5'h1) ? ST_DATA : ST_WL_WAIT;
        end
      end
      ST_WL_WAIT: begin
        if (wl_count == 5'h2) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (win_count == WIN_LEN - 3'h1) begin
          next_state = ST_PROGRAM;
        end
      end
      ST_PROGRAM: begin
        if (timer == '0) begin
          next_state = ST_WAIT_PRE;
        end
      end
      ST_WAIT_PRE: begin
        if (is_cmd(s_valid, s_code, CMD_PRE)) begin
          next_state = ST_EXIT_WAIT;
        end
      end
      ST_EXIT_WAIT: begin
        if (timer == '0) begin
          next_state = ST_WAIT_EXIT;
        end
      end
      ST_WAIT_EXIT: begin
        next_state = ST_WAIT_EXIT;
      end
      ST_SETTLE: begin
        if (timer == '0) begin
          next_state = ST_NORMAL;
        end
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
    // Clearing the entry bit leaves repair mode from any step; programming is not cut short.
    if (entry_clear && (state != ST_NORMAL) && (state != ST_SETTLE) && (state != ST_PROGRAM)) begin
      next_state = ST_SETTLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // One timer serves programming, exit and settling, loaded on the entering edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer <= '0;
    end else if (next_state != state) begin
      case (next_state)
        ST_PROGRAM: timer <= PROG_LOAD;
        ST_EXIT_WAIT: timer <= EXIT_LOAD;
        ST_SETTLE: timer <= SET_LOAD;
        default: timer <= '0;
      endcase
    end else if (timer != '0) begin
      timer <= timer - TIMER_W'(1);
    end
  end

  // Guard key counter; the key writes only count, their contents are not checked.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_count <= '0;
    end else if (state != ST_KEY) begin
      key_count <= '0;
    end else if (mrs_zero) begin
      key_count <= key_count + 4'h1;
    end
  end

  // Row capture; the write's column and bank fields are deliberately dropped.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      target_row <= '0;
      target_bank <= '0;
      auto_pre <= 1'b0;
      wl_count <= '0;
    end else begin
      if ((state == ST_ARMED) && is_cmd(s_valid, s_code, CMD_ACT)) begin
        target_row <= s_addr;
        target_bank <= bank_of(s_bg, s_ba);
      end
      if ((state == ST_ROW_OPEN) && (next_state != state)) begin
        auto_pre <= (s_code == CMD_WRA);
        wl_count <= write_latency;
      end else if ((state == ST_WL_WAIT) && (wl_count != '0)) begin
        wl_count <= wl_count - 5'h1;
      end
    end
  end

  // Data window judge: four lows repair, a run of two highs skips, else unknown.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_count <= '0;
      high_run <= '0;
      all_low <= 1'b1;
      saw_skip <= 1'b0;
      outcome <= OUT_NONE;
    end else if (state == ST_DATA) begin
      win_count <= win_count + 3'h1;
      all_low <= all_low && dq_low;
      high_run <= dq_high ? high_run + 3'h1 : 3'h0;
      if (dq_high && (high_run + 3'h1 >= HIGH_RUN)) begin
        saw_skip <= 1'b1;
      end
      if (win_count == WIN_LEN - 3'h1) begin
        if (all_low && dq_low) begin
          outcome <= OUT_REPAIR;
        end else if (saw_skip || (dq_high && (high_run + 3'h1 >= HIGH_RUN))) begin
          outcome <= OUT_SKIP;
        end else begin
          outcome <= OUT_UNKNOWN;
        end
      end
    end else begin
      win_count <= '0;
      high_run <= '0;
      all_low <= 1'b1;
      saw_skip <= 1'b0;
      if (entry_set && (state == ST_NORMAL)) begin
        outcome <= OUT_NONE;
      end
    end
  end

  // A non-refresh command while programming is recorded; the repair may be incomplete.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      disturbed <= 1'b0;
    end else if (entry_set && (state == ST_NORMAL)) begin
      disturbed <= 1'b0;
    end else if ((state == ST_PROGRAM) && s_valid && !is_ref) begin
      disturbed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Fuse programming at the end of the programming wait; unknown outcomes never burn.
  logic burn;
  assign burn = (state == ST_PROGRAM) && (timer == '0) && (outcome == OUT_REPAIR);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_fire <= 1'b0;
      fuse_row <= '0;
      fuse_bank <= '0;
      fill <= '0;
      repair_count <= '0;
      row_used <= '0;
    end else begin
      fuse_fire <= burn;
      if (burn) begin
        fuse_row <= target_row;
        fuse_bank <= target_bank;
        row_used[fill] <= 1'b1;
        fill <= (fill == IDX_W'(ROWS - 1)) ? '0 : fill + IDX_W'(1);
        repair_count <= repair_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (burn) begin
      row_table[fill] <= target_row;
      bank_table[fill] <= target_bank;
    end
  end

  // Normal activates that land on a repaired row are steered to the spare.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remap_hit <= 1'b0;
    end else begin
      remap_hit <= 1'b0;
      for (int i = 0; i < ROWS; i++) begin
        if (row_used[i] && (state == ST_NORMAL) && is_cmd(s_valid, s_code, CMD_ACT)
            && (row_table[i] == s_addr) && (bank_table[i] == bank_of(s_bg, s_ba))) begin
          remap_hit <= 1'b1;
        end
      end
    end
  end

  // Refresh in repair mode spares only the pair of banks holding the target row.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_go <= 1'b0;
      refresh_keep <= '0;
    end else begin
      refresh_go <= is_ref;
      refresh_keep <= 8'hFF;
      if (is_ref && (state != ST_NORMAL) && (state != ST_SETTLE || repair_mode)) begin
        refresh_keep[{target_bank[2:1], 1'b0}] <= 1'b0;
        refresh_keep[{target_bank[2:1], 1'b1}] <= 1'b0;
      end
    end
  end

  always_comb begin
    repair_mode = (state != ST_NORMAL) && (state != ST_SETTLE);
    accept_cmd = (state != ST_SETTLE);
    support_page = 8'h00;
    support_page[SUP_PERM_BIT] = PERM_SUPPORT;
    support_page[SUP_TEMP_BIT] = TEMP_SUPPORT;
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_latency <= WL_RESET;
    end else if (reg_write && (reg_addr == REG_CTRL)) begin
      write_latency <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_read) begin
        case (reg_addr)
          REG_CTRL: reg_rdata <= {27'h0, write_latency};
          REG_STATUS: reg_rdata <= {8'h0, repair_count, auto_pre, disturbed,
                                    outcome, state, 1'b0};
          REG_SUPPORT: reg_rdata <= {24'h0, support_page};
          REG_LAST_ROW: reg_rdata <= {11'h0, fuse_bank, fuse_row};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule : row_repair

//--- verification/row_repair_properties.sv
// Concurrent checks on the ports of the permanent row repair sequencer.
// Assumes pin commands reach the state register three edges after they are applied.
module row_repair_properties
  import row_repair_pkg::*;
#(
  parameter bit PERM_SUPPORT = 1'b1,
  parameter bit TEMP_SUPPORT = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Command bus.
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [1:0] cmd_bg,
  input wire logic [1:0] cmd_ba,
  input wire logic [17:0] cmd_addr,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // Array side.
  input wire logic repair_mode,
  input wire logic accept_cmd,
  input wire logic fuse_fire,
  input wire logic refresh_go,
  input wire logic [7:0] refresh_keep,
  input wire logic remap_hit,
  input wire logic [7:0] support_page
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Counts the settle cycles, far too many to unroll as a repetition.
  logic [9:0] low_cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= 10'h000;
    end else if (!accept_cmd) begin
      low_cnt <= low_cnt + 10'h001;
    end else begin
      low_cnt <= 10'h000;
    end
  end

  sequence s_cmd(logic [2:0] code);
    cmd_valid && cmd_code == code;
  endsequence
  sequence s_entry;
    s_cmd(CMD_MRS) ##0 ({cmd_bg[0], cmd_ba} == MR_FOUR && cmd_addr[ENTRY_BIT]
      && !repair_mode && accept_cmd);
  endsequence

  AST_MODE_ENTRY: assert property (s_entry |-> ##3 repair_mode)
    else $error("repair mode not entered after entry write");
  AST_REFRESH_GO: assert property (s_cmd(CMD_REF) |-> ##3 refresh_go)
    else $error("refresh pulse missing after refresh command");
  AST_KEEP_REPAIR: assert property (refresh_go && repair_mode |-> $countones(refresh_keep) == 6)
    else $error("refresh in repair mode does not spare exactly two banks");
  AST_FIRE_PULSE: assert property (fuse_fire |-> repair_mode ##1 (!fuse_fire && repair_mode))
    else $error("fuse fire is not a single pulse inside repair mode");
  AST_SETTLE_LEN: assert property ($rose(accept_cmd) |-> low_cnt == SET_CYCLES)
    else $error("settle time after exit has the wrong length");
  AST_SETTLE_OUT: assert property (!accept_cmd |-> !repair_mode && !fuse_fire)
    else $error("repair activity during settle time");
  AST_REMAP_NORMAL: assert property (remap_hit |-> !repair_mode && accept_cmd)
    else $error("remap hit outside normal operation");
  AST_SUPPORT: assert property (support_page == {PERM_SUPPORT, TEMP_SUPPORT, 6'h00})
    else $error("support page does not match support options");
  AST_SUPPORT_READ: assert property (reg_read && reg_addr == REG_SUPPORT
    |=> reg_rdata == {24'h000000, support_page})
    else $error("support register read returns wrong value");
endmodule : row_repair_properties

bind row_repair row_repair_properties #(
  .PERM_SUPPORT(PERM_SUPPORT),
  .TEMP_SUPPORT(TEMP_SUPPORT)
) u_props (
  .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bg(cmd_bg),
  .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .repair_mode(repair_mode), .accept_cmd(accept_cmd),
  .fuse_fire(fuse_fire), .refresh_go(refresh_go), .refresh_keep(refresh_keep),
  .remap_hit(remap_hit), .support_page(support_page)
);

//--- verification/repair_host_model.sv
// Behavioural memory controller driving repair entry, guard key, write, data and exit.
// Assumes the testbench calls its tasks one at a time, in sequence order.
module repair_host_model
  import row_repair_pkg::*;
#(
  parameter int MOD_GAP = 4,
  parameter int RCD_GAP = 2
) (
  // Clock.
  input wire logic clk,
  // Command bus and data lines.
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [1:0] cmd_bg,
  output logic [1:0] cmd_ba,
  output logic [17:0] cmd_addr,
  output logic [15:0] dq
);
  logic [5:0] pat_q = 6'h00;
  logic [2:0] pat_n = 3'h0;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_bg = 2'h0;
    cmd_ba = 2'h0;
    cmd_addr = 18'h00000;
    dq = 16'h5A5A;
  end

  // Released data lines walk, so a stale level never looks like a window value.
  always @(posedge clk) begin
    if (pat_n != 3'h0) begin
      dq <= {16{pat_q[0]}};
      pat_q <= pat_q >> 1;
      pat_n <= pat_n - 3'h1;
    end else begin
      dq <= {dq[14:0], ~dq[15]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic issue(input logic [2:0] code, input logic [2:0] sel, input logic [17:0] addr);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_bg <= {1'b0, sel[2]};
    cmd_ba <= sel[1:0];
    cmd_addr <= addr;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~addr;
  endtask : issue

  // Banks are taken as precharged, with inversion and CRC off, before entry.
  task automatic enter();
    issue(CMD_MRS, MR_FOUR, 18'h02000);
    repeat (MOD_GAP) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      issue(CMD_MRS, MR_ZERO, 18'h3F07F | (18'(i) << 7));
      repeat (MOD_GAP) @(posedge clk);
    end
  endtask : enter

  // The write carries a foreign bank and column, which the device ignores.
  // Six beats straddle the four-beat window by one cycle on each side.
  task automatic write_row(input logic [17:0] row, input logic [2:0] bank, input bit wra,
      input int wl, input logic [5:0] pat);
    issue(CMD_ACT, bank, row);
    repeat (RCD_GAP) @(posedge clk);
    issue(wra ? CMD_WRA : CMD_WR, ~bank, 18'h00155);
    repeat (wl - 3) @(posedge clk);
    pat_q <= pat;
    pat_n <= 3'h6;
    repeat (8) @(posedge clk);
  endtask : write_row

  task automatic refresh();
    issue(CMD_REF, 3'h0, 18'h00000);
  endtask : refresh

  // Called only once programming has run out, as nothing but refresh may arrive before.
  task automatic leave(input logic [2:0] bank);
    issue(CMD_PRE, bank, 18'h00000);
    repeat (EXIT_CYCLES + 1) @(posedge clk);
    issue(CMD_MRS, MR_FOUR, 18'h00000);
  endtask : leave
endmodule : repair_host_model

//--- verification/tb_row_repair.sv
// Self-checking bench for the permanent row repair sequencer.
// Assumes the host model drives commands and data; registers are driven from here.
module tb_row_repair
  import row_repair_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PROG = 20;
  localparam int WL = 6;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid, reg_write = 1'b0, reg_read = 1'b0;
  logic [2:0] cmd_code, fuse_bank;
  logic [1:0] cmd_bg, cmd_ba;
  logic [17:0] cmd_addr, fuse_row;
  logic [15:0] dq;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
  logic repair_mode, accept_cmd, fuse_fire, refresh_go, remap_hit;
  logic [7:0] refresh_keep, support_page;
  int mismatches = 0;
  int n_compared = 0;
  int fires = 0;

  always #50 clk = ~clk;
  always @(posedge clk) if (fuse_fire === 1'b1) fires <= fires + 1;

  row_repair #(.PROG_CYCLES_P(PROG)) uut (
    .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bg(cmd_bg),
    .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .dq(dq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .repair_mode(repair_mode), .accept_cmd(accept_cmd),
    .fuse_fire(fuse_fire), .fuse_row(fuse_row), .fuse_bank(fuse_bank),
    .refresh_go(refresh_go), .refresh_keep(refresh_keep), .remap_hit(remap_hit),
    .support_page(support_page)
  );
  repair_host_model host (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bg(cmd_bg),
    .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .dq(dq)
  );

  ////////////////////////////////////////////////////////////////////////////////

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  function automatic logic sig(input int i);
    case (i)
      0: return refresh_go;
      1: return accept_cmd;
      default: return remap_hit;
    endcase
  endfunction : sig

  task automatic await(input int i, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig(i) !== lvl) begin
      @(posedge clk);
      #1 n++;
      if (n > lim) begin
        chk("wait", 32'(sig(i)), 32'(lvl));
        test_done();
      end
    end
  endtask : await

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd

  ////////////////////////////////////////////////////////////////////////////////

  task automatic check_regs();
    logic [31:0] d;
    reg_rd(REG_CTRL, d);
    chk("wl_reset", d, 32'(WL_RESET));
    reg_wr(REG_CTRL, 32'(WL));
    reg_rd(REG_CTRL, d);
    chk("wl", d, 32'(WL));
    reg_rd(REG_SUPPORT, d);
    chk("support", d, 32'h00000080);
    chk("support_page", 32'(support_page), 32'h00000080);
    reg_wr(4'h2, 32'hFFFFFFFF);
    reg_rd(4'h2, d);
    chk("unmapped", d, 32'h00000000);
  endtask : check_regs

  // Whole repair pass; only the auto-precharge variant refreshes while programming.
  task automatic run(input bit wra, input logic [5:0] pat, input logic [17:0] row,
      input logic [2:0] bank, input logic [1:0] exp_out);
    logic [31:0] d;
    logic [7:0] keep;
    int n;
    int f0;
    f0 = fires;
    keep = ~(8'h03 << {bank[2:1], 1'b0});
    host.enter();
    chk("mode_entry", 32'(repair_mode), 32'h00000001);
    host.write_row(row, bank, wra, WL, pat);
    if (wra) begin
      host.refresh();
      await(0, 1'b1, 10, n);
      chk("keep_repair", 32'(refresh_keep), 32'(keep));
    end
    repeat (PROG + 15) @(posedge clk);
    chk("fires", fires - f0, 32'(exp_out == OUT_REPAIR));
    reg_rd(REG_STATUS, d);
    chk("status", {d[13:12], d[8]}, {exp_out, 1'b1});
    host.leave(bank);
    await(1, 1'b0, 20, n);
    await(1, 1'b1, 600, n);
    chk("settle", n, SET_CYCLES);
    chk("mode_exit", 32'(repair_mode), 32'h00000000);
  endtask : run

  task automatic check_after();
    logic [31:0] d;
    int n;
    host.issue(CMD_MRS, MR_ZERO, 18'h00000);
    host.issue(CMD_ACT, 3'h5, 18'h12345);
    await(2, 1'b1, 10, n);
    host.issue(CMD_PRE, 3'h5, 18'h00000);
    host.refresh();
    await(0, 1'b1, 10, n);
    chk("keep_normal", 32'(refresh_keep), 32'h000000FF);
    reg_rd(REG_LAST_ROW, d);
    chk("last_row", d, 32'h00152345);
    reg_rd(REG_STATUS, d);
    chk("count", 32'(d[23:16]), 32'h00000001);
  endtask : check_after

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check_regs();
    run(1'b1, 6'h00, 18'h12345, 3'h5, OUT_REPAIR);
    chk("fuse_row", 32'(fuse_row), 32'h00012345);
    chk("fuse_bank", 32'(fuse_bank), 32'h00000005);
    run(1'b0, 6'h3F, 18'h00777, 3'h2, OUT_SKIP);
    run(1'b0, 6'h2A, 18'h00999, 3'h6, OUT_UNKNOWN);
    check_after();
    test_done();
  end
endmodule : tb_row_repair
